// [hdl/pwr_clk_pkg.sv]
// Constants, register map and field layout of the key-guarded power and clock control
// Operation
// - Core register commits only after key 0x01, value write, then key 0xf4.
// - Peripheral register commits only after key 0x76, value write, then key 0xb1.
// - Mode field bits 6:4; 011 sleep wakes on interrupt inputs 0-3 or second timer.
// - Mode 100 is stop; only interrupt inputs 0-3 wake it, timers ignored.
// - Core clock is system clock divided by two to the power of bits 2:0.
// - Bit 11 clear powers down PWM; software keeps bits 10:9 at 00.
// - Bit 8 clear powers down the SPI block.
// - SPI divider bits 7:6 select divide by 1, 2, 4 or 8.
// - Bit 5 clear powers down second I2C, bit 2 the first I2C.
// - Second I2C divider bits 4:3 select divide by 1, 4, 8 or 32.
// - First I2C divider bits 1:0 use the same four rates.
// - Core divider resets to three, system clock divided by 8.
package pwr_clk_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] CORE_KEY_FIRST_ADDR = 32'hffff0404;
    localparam logic [31:0] CORE_CTRL_ADDR = 32'hffff0408;
    localparam logic [31:0] CORE_KEY_SECOND_ADDR = 32'hffff040c;
    localparam logic [31:0] PERIPH_KEY_FIRST_ADDR = 32'hffff0434;
    localparam logic [31:0] PERIPH_CTRL_ADDR = 32'hffff0438;
    localparam logic [31:0] PERIPH_KEY_SECOND_ADDR = 32'hffff043c;

    // ------------------------------------------------------------
    // Key codes
    // ------------------------------------------------------------
    localparam logic [15:0] CORE_KEY_FIRST_VAL = 16'h0001;
    localparam logic [15:0] CORE_KEY_SECOND_VAL = 16'h00f4;
    localparam logic [15:0] PERIPH_KEY_FIRST_VAL = 16'h0076;
    localparam logic [15:0] PERIPH_KEY_SECOND_VAL = 16'h00b1;

    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] CORE_CTRL_RESET = 8'h03;
    localparam logic [7:0] CORE_CTRL_MASK = 8'h77;
    localparam logic [15:0] PERIPH_CTRL_RESET = 16'h0124;
    localparam logic [15:0] PERIPH_CTRL_MASK = 16'h0fff;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE_LSB = 4;
    localparam int MODE_MSB = 6;
    localparam int CD_LSB = 0;
    localparam int CD_MSB = 2;
    localparam int PWM_PO_BIT = 11;
    localparam int SPI_PO_BIT = 8;
    localparam int SPI_DIV_LSB = 6;
    localparam int I2C2_PO_BIT = 5;
    localparam int I2C2_DIV_LSB = 3;
    localparam int I2C1_PO_BIT = 2;
    localparam int I2C1_DIV_LSB = 0;

    // Operating modes
    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'h0,
        MODE_PAUSE = 3'h1,
        MODE_NAP = 3'h2,
        MODE_SLEEP = 3'h3,
        MODE_STOP = 3'h4
    } op_mode_e;

    // Key sequence states, gray coded
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_KEYED = 2'b01,
        SEQ_VALUE = 2'b11
    } seq_state_e;

    // Divider width: up to divide by 128
    localparam int DIV_W = 7;

    // Peripheral divider shift per code
    localparam logic [2:0] SPI_SHIFT [4] = '{3'h0, 3'h1, 3'h2, 3'h3};
    localparam logic [2:0] I2C_SHIFT [4] = '{3'h0, 3'h2, 3'h3, 3'h5};

endpackage

// [hdl/clk_div_enable.sv]
// Power-of-two clock enable generator
`timescale 1ns/1ps
module clk_div_enable (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic run_in,
    input wire logic [2:0] shift_in,
    output logic tick_out
);
    import pwr_clk_pkg::*;

    logic [pwr_clk_pkg::DIV_W-1:0] cnt_q;
    logic [pwr_clk_pkg::DIV_W-1:0] limit;

    assign limit = DIV_W'((1 << shift_in) - 1);

    // --------------------------------
    // Counter and tick
    // --------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end else if (!run_in) begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end else if (cnt_q >= limit) begin
            cnt_q <= '0;
            tick_out <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_out <= 1'b0;
        end
    end
endmodule

// [hdl/key_guarded_power_clock_control.sv]
// Key-guarded power and clock control with Wishbone slave
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module key_guarded_power_clock_control (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [31:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [3:0] external_interrupt_input_in,
    input wire logic second_timer_in,
    output logic [2:0] operating_mode_out,
    output logic core_clk_en_out,
    output logic core_halted_out,
    output logic periph_run_out,
    output logic pwm_power_on_out,
    output logic spi_power_on_out,
    output logic spi_clk_en_out,
    output logic second_i2c_power_on_out,
    output logic second_i2c_clk_en_out,
    output logic first_i2c_power_on_out,
    output logic first_i2c_clk_en_out
);
    import pwr_clk_pkg::*;

    logic [7:0] core_ctrl_q;
    logic [15:0] periph_ctrl_q;
    logic [7:0] core_pend_q;
    logic [15:0] periph_pend_q;
    seq_state_e core_seq_q;
    seq_state_e periph_seq_q;
    logic [2:0] mode_q;
    logic core_run_q;
    logic periph_run_q;

    logic bus_req;
    logic wr_stb;
    logic [15:0] wdata;
    logic hit_ck1, hit_cc, hit_ck2, hit_pk1, hit_pc, hit_pk2;
    logic wake;
    logic core_commit;
    logic core_tick, spi_tick, i2c2_tick, i2c1_tick;
    logic [1:0] spi_code, i2c2_code, i2c1_code;

    // --------------------------------
    // Bus decode
    // --------------------------------
    assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wr_stb = bus_req && wb_we_in;
    assign wdata = {wb_sel_in[1] ? wb_dat_in[15:8] : 8'h00, wb_sel_in[0] ? wb_dat_in[7:0] : 8'h00};
    assign hit_ck1 = wb_adr_in == CORE_KEY_FIRST_ADDR;
    assign hit_cc = wb_adr_in == CORE_CTRL_ADDR;
    assign hit_ck2 = wb_adr_in == CORE_KEY_SECOND_ADDR;
    assign hit_pk1 = wb_adr_in == PERIPH_KEY_FIRST_ADDR;
    assign hit_pc = wb_adr_in == PERIPH_CTRL_ADDR;
    assign hit_pk2 = wb_adr_in == PERIPH_KEY_SECOND_ADDR;

    // One-cycle acknowledge for every address; unmapped reads return zero
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= bus_req;
        end
    end

    // --------------------------------
    // Read data
    // --------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wb_dat_out <= 32'h0000_0000;
        end else if (bus_req && !wb_we_in) begin
            if (hit_cc) begin
                wb_dat_out <= {24'h00_0000, core_ctrl_q};
            end else if (hit_pc) begin
                wb_dat_out <= {16'h0000, periph_ctrl_q};
            end else begin
                wb_dat_out <= 32'h0000_0000;
            end
        end
    end

    // --------------------------------
    // Core key sequence
    // --------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            core_seq_q <= SEQ_IDLE;
            core_pend_q <= CORE_CTRL_RESET;
        end else if (wr_stb && (hit_ck1 || hit_cc || hit_ck2)) begin
            case (core_seq_q)
                SEQ_IDLE: begin
                    if (hit_ck1 && wdata == CORE_KEY_FIRST_VAL) begin
                        core_seq_q <= SEQ_KEYED;
                    end
                end
                SEQ_KEYED: begin
                    if (hit_cc) begin
                        core_pend_q <= wdata[7:0] & CORE_CTRL_MASK;
                        core_seq_q <= SEQ_VALUE;
                    end else begin
                        core_seq_q <= SEQ_IDLE;
                    end
                end
                SEQ_VALUE: begin
                    core_seq_q <= SEQ_IDLE;
                end
                default: begin
                    core_seq_q <= SEQ_IDLE;
                end
            endcase
        end
    end

    assign core_commit = wr_stb && hit_ck2 && core_seq_q == SEQ_VALUE
        && wdata == CORE_KEY_SECOND_VAL;

    // --------------------------------
    // Peripheral key sequence
    // --------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            periph_seq_q <= SEQ_IDLE;
            periph_pend_q <= PERIPH_CTRL_RESET;
        end else if (wr_stb && (hit_pk1 || hit_pc || hit_pk2)) begin
            case (periph_seq_q)
                SEQ_IDLE: begin
                    if (hit_pk1 && wdata == PERIPH_KEY_FIRST_VAL) begin
                        periph_seq_q <= SEQ_KEYED;
                    end
                end
                SEQ_KEYED: begin
                    if (hit_pc) begin
                        periph_pend_q <= wdata & PERIPH_CTRL_MASK;
                        periph_seq_q <= SEQ_VALUE;
                    end else begin
                        periph_seq_q <= SEQ_IDLE;
                    end
                end
                SEQ_VALUE: begin
                    periph_seq_q <= SEQ_IDLE;
                end
                default: begin
                    periph_seq_q <= SEQ_IDLE;
                end
            endcase
        end
    end

    // --------------------------------
    // Committed registers
    // --------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            periph_ctrl_q <= PERIPH_CTRL_RESET;
        end else if (wr_stb && hit_pk2 && periph_seq_q == SEQ_VALUE
                     && wdata == PERIPH_KEY_SECOND_VAL) begin
            periph_ctrl_q <= periph_pend_q;
        end
    end

    // Wake sources by mode; timer ignored in stop
    always_comb begin
        case (op_mode_e'(core_ctrl_q[MODE_MSB:MODE_LSB]))
            MODE_PAUSE, MODE_NAP: wake = |external_interrupt_input_in || second_timer_in;
            MODE_SLEEP: wake = |external_interrupt_input_in || second_timer_in;
            MODE_STOP: wake = |external_interrupt_input_in;
            default: wake = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            core_ctrl_q <= CORE_CTRL_RESET;
        end else if (core_commit) begin
            core_ctrl_q <= core_pend_q;
        end else if (wake) begin
            core_ctrl_q[MODE_MSB:MODE_LSB] <= MODE_ACTIVE;
        end
    end

    // --------------------------------
    // Power state from mode
    // --------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_q <= MODE_ACTIVE;
            core_run_q <= 1'b1;
            periph_run_q <= 1'b1;
        end else begin
            mode_q <= core_ctrl_q[MODE_MSB:MODE_LSB];
            core_run_q <= core_ctrl_q[MODE_MSB:MODE_LSB] == MODE_ACTIVE;
            periph_run_q <= core_ctrl_q[MODE_MSB:MODE_LSB] == MODE_ACTIVE
                || core_ctrl_q[MODE_MSB:MODE_LSB] == MODE_PAUSE;
        end
    end

    // --------------------------------
    // Clock enables
    // --------------------------------
    assign spi_code = periph_ctrl_q[SPI_DIV_LSB+1:SPI_DIV_LSB];
    assign i2c2_code = periph_ctrl_q[I2C2_DIV_LSB+1:I2C2_DIV_LSB];
    assign i2c1_code = periph_ctrl_q[I2C1_DIV_LSB+1:I2C1_DIV_LSB];

    clk_div_enable u_core_div (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .run_in(core_run_q),
        .shift_in(core_ctrl_q[CD_MSB:CD_LSB]),
        .tick_out(core_tick)
    );

    clk_div_enable u_spi_div (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .run_in(periph_run_q && periph_ctrl_q[SPI_PO_BIT]),
        .shift_in(SPI_SHIFT[spi_code]),
        .tick_out(spi_tick)
    );

    clk_div_enable u_i2c2_div (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .run_in(periph_run_q && periph_ctrl_q[I2C2_PO_BIT]),
        .shift_in(I2C_SHIFT[i2c2_code]),
        .tick_out(i2c2_tick)
    );

    clk_div_enable u_i2c1_div (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .run_in(periph_run_q && periph_ctrl_q[I2C1_PO_BIT]),
        .shift_in(I2C_SHIFT[i2c1_code]),
        .tick_out(i2c1_tick)
    );

    // --------------------------------
    // Registered outputs
    // --------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            operating_mode_out <= MODE_ACTIVE;
            core_clk_en_out <= 1'b0;
            core_halted_out <= 1'b0;
            periph_run_out <= 1'b1;
            pwm_power_on_out <= 1'b1;
            spi_power_on_out <= 1'b1;
            spi_clk_en_out <= 1'b0;
            second_i2c_power_on_out <= 1'b1;
            second_i2c_clk_en_out <= 1'b0;
            first_i2c_power_on_out <= 1'b1;
            first_i2c_clk_en_out <= 1'b0;
        end else begin
            operating_mode_out <= mode_q;
            core_clk_en_out <= core_tick;
            core_halted_out <= !core_run_q;
            periph_run_out <= periph_run_q;
            pwm_power_on_out <= periph_ctrl_q[PWM_PO_BIT];
            spi_power_on_out <= periph_ctrl_q[SPI_PO_BIT];
            spi_clk_en_out <= spi_tick;
            second_i2c_power_on_out <= periph_ctrl_q[I2C2_PO_BIT];
            second_i2c_clk_en_out <= i2c2_tick;
            first_i2c_power_on_out <= periph_ctrl_q[I2C1_PO_BIT];
            first_i2c_clk_en_out <= i2c1_tick;
        end
    end
endmodule

// [verif/key_guarded_power_clock_control_chk.sv]
// Assertion checker for the power and clock control block
`timescale 1ns/1ps
module pwr_clk_chk (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [31:0] wb_adr_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic [3:0] external_interrupt_input_in,
    input wire logic second_timer_in,
    input wire logic [2:0] operating_mode_out,
    input wire logic core_clk_en_out,
    input wire logic core_halted_out,
    input wire logic spi_power_on_out,
    input wire logic spi_clk_en_out,
    input wire logic second_i2c_power_on_out,
    input wire logic second_i2c_clk_en_out
);
    import pwr_clk_pkg::*;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    logic req;
    logic [2:0] m;
    assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign m = operating_mode_out;
    ack_next_a: assert property (req |=> wb_ack_out)
        else $error("ack missing");
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack too long");
    key_read_zero_a: assert property (
        req && !wb_we_in && wb_adr_in == CORE_KEY_SECOND_ADDR |=> wb_dat_out == 32'h0)
        else $error("key read not zero");
    halt_mode_a: assert property ((m != 3'h0)[*2] |-> core_halted_out)
        else $error("core not halted");
    no_core_tick_a: assert property ((m != 3'h0)[*2] |-> !core_clk_en_out)
        else $error("core ticks in low power");
    stop_hold_a: assert property (
        (!wb_cyc_in && m == 3'h4 && external_interrupt_input_in == 4'h0)[*4] |=> m == 3'h4)
        else $error("stop left without interrupt");
    timer_wake_a: assert property (
        (!wb_cyc_in)[*3] ##0 (m inside {3'h1, 3'h2, 3'h3} && second_timer_in)
        |-> ##3 m == 3'h0)
        else $error("timer wake missing");
    irq_wake_a: assert property (
        (!wb_cyc_in)[*3] ##0 (m != 3'h0 && m < 3'h5 && external_interrupt_input_in != 4'h0)
        |-> ##3 m == 3'h0)
        else $error("interrupt wake missing");
    spi_off_a: assert property ((!spi_power_on_out)[*2] |-> !spi_clk_en_out)
        else $error("spi clock while off");
    i2c_off_a: assert property (
        (!second_i2c_power_on_out)[*2] |-> !second_i2c_clk_en_out)
        else $error("i2c clock while off");
    cover property (m == 3'h4 ##1 m == 3'h0);
    cover property (m == 3'h3 ##1 m == 3'h0);
    cover property (req && wb_we_in);
endmodule

bind key_guarded_power_clock_control pwr_clk_chk chk_i (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .external_interrupt_input_in(external_interrupt_input_in),
    .second_timer_in(second_timer_in), .operating_mode_out(operating_mode_out),
    .core_clk_en_out(core_clk_en_out), .core_halted_out(core_halted_out),
    .spi_power_on_out(spi_power_on_out), .spi_clk_en_out(spi_clk_en_out),
    .second_i2c_power_on_out(second_i2c_power_on_out),
    .second_i2c_clk_en_out(second_i2c_clk_en_out)
);

// [verif/test_key_guarded_power_clock_control.sv]
// Self-checking bench for the power and clock control block
`timescale 1ns/1ps
module test_key_guarded_power_clock_control;
    import pwr_clk_pkg::*;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] irq = 4'h0;
    logic tmr = 1'b0;
    wire [31:0] rdat;
    wire ack;
    wire [2:0] mode;
    wire halted;
    wire prun;
    wire [3:0] tk;
    wire [3:0] pw;
    logic [31:0] rd;
    int c[4];
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int sp[4] = '{1, 2, 4, 8};
    int ip[4] = '{1, 4, 8, 32};

    key_guarded_power_clock_control uut (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .external_interrupt_input_in(irq),
        .second_timer_in(tmr), .operating_mode_out(mode), .core_clk_en_out(tk[0]),
        .core_halted_out(halted), .periph_run_out(prun), .pwm_power_on_out(pw[3]),
        .spi_power_on_out(pw[2]), .spi_clk_en_out(tk[1]),
        .second_i2c_power_on_out(pw[1]), .second_i2c_clk_en_out(tk[2]),
        .first_i2c_power_on_out(pw[0]), .first_i2c_clk_en_out(tk[3])
    );

    always #20 sys_clk_in = ~sys_clk_in;

    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge sys_clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge sys_clk_in);
        end while (ack !== 1'b1);
        rd = rdat;
        chk(ack, 1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask

    task automatic keyed(input logic [31:0] b, input logic [15:0] k1, v, k2);
        xfer(b, 1'b1, {16'h0, k1});
        xfer(b + 32'h4, 1'b1, {16'h0, v});
        xfer(b + 32'h8, 1'b1, {16'h0, k2});
    endtask

    task automatic cnt(input int skip, input int n);
        repeat (skip) @(posedge sys_clk_in);
        c = '{0, 0, 0, 0};
        repeat (n) begin
            @(posedge sys_clk_in);
            for (int k = 0; k < 4; k++) c[k] += int'(tk[k]);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rdchk(CORE_CTRL_ADDR, 32'h03);
        rdchk(PERIPH_CTRL_ADDR, 32'h124);
        rdchk(CORE_KEY_FIRST_ADDR, 32'h0);
        rdchk(32'hffff0500, 32'h0);
        chk(pw, 4'h7);
        cnt(0, 64);
        chk(c[0], 8);
    endtask

    task automatic t_core_div();
        keyed(CORE_KEY_FIRST_ADDR, 16'h01, 16'h00, 16'hf4);
        rdchk(CORE_CTRL_ADDR, 32'h00);
        cnt(8, 16);
        chk(c[0], 16);
        // Slowest core clock: divide by 128, two core ticks in 256 cycles
        keyed(CORE_KEY_FIRST_ADDR, 16'h01, 16'h07, 16'hf4);
        rdchk(CORE_CTRL_ADDR, 32'h07);
        cnt(128, 256);
        chk(c[0], 2);
    endtask

    task automatic t_bad_keys();
        keyed(CORE_KEY_FIRST_ADDR, 16'h02, 16'h27, 16'hf4);
        keyed(CORE_KEY_FIRST_ADDR, 16'h01, 16'h27, 16'hf5);
        rdchk(CORE_CTRL_ADDR, 32'h07);
        chk(mode, 3'h0);
        keyed(PERIPH_KEY_FIRST_ADDR, 16'h76, 16'h0, 16'hb0);
        rdchk(PERIPH_CTRL_ADDR, 32'h124);
    endtask

    task automatic t_periph();
        logic [15:0] v;
        for (int k = 0; k < 4; k++) begin
            v = 16'h0124 | 16'(k << 6) | 16'(k << 3) | 16'(k) | (k == 3 ? 16'h0800 : 16'h0);
            keyed(PERIPH_KEY_FIRST_ADDR, 16'h76, v, 16'hb1);
            rdchk(PERIPH_CTRL_ADDR, {16'h0, v});
            chk(pw[3], k == 3);
            cnt(64, 64);
            chk(c[1], 64 / sp[k]);
            chk(c[2], 64 / ip[k]);
            chk(c[3], 64 / ip[k]);
        end
        keyed(PERIPH_KEY_FIRST_ADDR, 16'h76, 16'h0, 16'hb1);
        cnt(4, 32);
        chk(pw, 4'h0);
        chk(c[1], 0);
        chk(c[2] + c[3], 0);
        keyed(PERIPH_KEY_FIRST_ADDR, 16'h76, 16'h0124, 16'hb1);
    endtask

    task automatic t_modes();
        for (int m = 1; m < 4; m++) begin
            keyed(CORE_KEY_FIRST_ADDR, 16'h01, 16'(m << 4) | 16'h07, 16'hf4);
            repeat (4) @(posedge sys_clk_in);
            chk(mode, m);
            chk(halted, 1);
            chk(prun, m == 1);
            tmr <= 1'b1;
            repeat (4) @(posedge sys_clk_in);
            chk(mode, 3'h0);
            tmr <= 1'b0;
            rdchk(CORE_CTRL_ADDR, 32'h07);
        end
        for (int b = 0; b < 4; b++) begin
            keyed(CORE_KEY_FIRST_ADDR, 16'h01, 16'h47, 16'hf4);
            tmr <= 1'b1;
            cnt(4, 16);
            chk(mode, 3'h4);
            chk(c[0], 0);
            tmr <= 1'b0;
            irq <= 4'(1 << b);
            repeat (4) @(posedge sys_clk_in);
            chk(mode, 3'h0);
            irq <= 4'h0;
        end
        // Reserved mode code: stored, halted, no wake
        keyed(CORE_KEY_FIRST_ADDR, 16'h01, 16'h57, 16'hf4);
        irq <= 4'hf;
        repeat (4) @(posedge sys_clk_in);
        chk(mode, 3'h5);
        chk(halted, 1);
        irq <= 4'h0;
        rdchk(CORE_CTRL_ADDR, 32'h57);
    endtask

    task automatic tally_and_finish();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_core_div();
        t_bad_keys();
        t_periph();
        t_modes();
        tally_and_finish();
    end
endmodule
